/* design/sms_pkg.sv */
/*
 * sms_pkg: shared constants and types of the supply monitor and status block.
 * assumes: one 100 MHz clock; the serial bus block outside passes the read
 * strobe and address, and this block decodes the condition register address.
 */
package sms_pkg;

  // clock and timing
  localparam int SMS_CLK_PERIOD_NS = 10;      // 100 MHz system clock
  localparam int SMS_POR_HOLD_NS = 1000;      // least hold of the restart reset
  localparam int SMS_POR_HOLD_CYC =           // rounded up to whole cycles
    (SMS_POR_HOLD_NS + SMS_CLK_PERIOD_NS - 1) / SMS_CLK_PERIOD_NS;
  localparam int SMS_CNT_W = 8;               // width of the hold counter
  localparam logic [SMS_CNT_W-1:0] SMS_POR_LAST = SMS_CNT_W'(SMS_POR_HOLD_CYC - 1);
  localparam logic [SMS_CNT_W-1:0] SMS_CNT_ZERO = 8'h00;

  // register map
  localparam int SMS_ADDR_W = 6;              // register address width
  localparam logic [SMS_ADDR_W-1:0] SMS_ADDR_COND = 6'h01;  // condition register

  // condition register fields
  localparam int SMS_BIT_LOCK = 0;            // synth lock fault
  localparam int SMS_BIT_PARITY = 1;          // config parity fault
  localparam int SMS_BIT_COLLAPSE = 2;        // supply collapse
  localparam int SMS_BIT_LB_EARLY = 4;        // battery below 2.4 V
  localparam int SMS_BIT_LB_DEEP = 5;         // battery below 2.1 V
  localparam logic [7:0] SMS_COND_RST = 8'h04;       // reset value of stored flags
  localparam logic [7:0] SMS_COND_IMPL = 8'h37;      // bits that hold state
  localparam logic [7:0] SMS_COND_FIXED1 = 8'h80;    // bit 7 always reads one
  localparam logic [7:0] SMS_COND_CLR_RD = 8'h07;    // cleared by a read
  localparam logic [7:0] SMS_COND_LB = 8'h30;        // cleared by transmit start
  localparam logic [7:0] SMS_BYTE_ZERO = 8'h00;

  // sensed analog comparator lines
  localparam int SMS_SNS_W = 4;
  localparam int SMS_SNS_REGULATED_RAIL = 0;            // regulated rail below collapse level
  localparam int SMS_SNS_VBAT = 1;            // battery rail below collapse level
  localparam int SMS_SNS_LB_DEEP = 2;         // battery below 2.1 V
  localparam int SMS_SNS_LB_EARLY = 3;        // battery below 2.4 V

  // power mode from the system controller
  typedef enum logic [1:0] {
    SMS_MODE_SLEEP = 2'b00,
    SMS_MODE_STANDBY = 2'b01,
    SMS_MODE_ACTIVE = 2'b10
  } sms_mode_t;

  // restart sequencer
  typedef enum logic [1:0] {
    SMS_ST_POR = 2'b00,
    SMS_ST_RUN = 2'b01,
    SMS_ST_COLLAPSE = 2'b10,
    SMS_ST_SLEEP = 2'b11
  } sms_seq_t;

endpackage : sms_pkg

/* design/sms_sense_if.sv */
/*
 * sms_sense_if: carries the raw comparator lines to the synchroniser and the
 * filtered levels back to the block's logic.
 * assumes: raw lines are asynchronous to the clock.
 */
`timescale 1ns/10ps
interface sms_sense_if;
  logic [sms_pkg::SMS_SNS_W-1:0] raw;     // comparator outputs as they arrive
  logic [sms_pkg::SMS_SNS_W-1:0] clean;   // synchronised and agreed levels

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : sms_sense_if

/* design/sms_sync3.sv */
/*
 * sms_sync3: three-stage synchroniser for the comparator lines; a level is
 * taken over only when the second and third stage agree.
 * assumes: one clock, asynchronous active-low reset, lines idle low.
 */
`timescale 1ns/10ps
module sms_sync3 (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // sensed lines
  sms_sense_if.sync sns
);

  logic [sms_pkg::SMS_SNS_W-1:0] ff1_r;     // first stage, read only by ff2
  logic [sms_pkg::SMS_SNS_W-1:0] ff2_r;     // second stage
  logic [sms_pkg::SMS_SNS_W-1:0] ff3_r;     // third stage
  logic [sms_pkg::SMS_SNS_W-1:0] clean_r;   // agreed level
  logic [sms_pkg::SMS_SNS_W-1:0] clean_nxt;
  logic [sms_pkg::SMS_SNS_W-1:0] agree;     // stages two and three equal

  // per-bit agreement filter
  always_comb begin
    agree = ~(ff2_r ^ ff3_r);
    clean_nxt = (agree & ff3_r) | (~agree & clean_r);
  end

  // shift chain and filtered level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      clean_r <= '0;
    end else begin
      ff1_r <= sns.raw;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      clean_r <= clean_nxt;
    end
  end

  assign sns.clean = clean_r;

  // a level changes only after two agreeing stages
  sync_agree_a: assert property (@(posedge clock) disable iff (!rst_b)
    (clean_r != $past(clean_r)) |-> ((clean_r & ~$past(agree)) == ($past(clean_r) & ~$past(agree))))
    else $error("filtered level moved without stage agreement");

endmodule : sms_sync3

/* design/sms_supply_monitor.sv */
/*
 * sms_supply_monitor: supply collapse and low battery supervision with the
 * transmitter condition register and the restart sequencer.
 * assumes: the serial bus block passes condition register reads as a strobe
 * with address; mode, transmit start, parity and lock inputs are synchronous.
 */
`timescale 1ns/10ps
module sms_supply_monitor (
  // clock and power-up reset
  input wire logic clock,
  input wire logic rst_b,
  // system controller
  input wire logic [1:0] mode_sel,
  input wire logic tx_start,
  input wire logic pa_on_req,
  // analog comparators, asynchronous
  input wire logic bod_regulated_rail_low,
  input wire logic bod_vbat_low,
  input wire logic lbd_below_deep,
  input wire logic lbd_below_early,
  // fault sources
  input wire logic parity_mismatch,
  input wire logic synth_unlock,
  // register read port
  input wire logic reg_rd_stb,
  input wire logic [sms_pkg::SMS_ADDR_W-1:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_hit,
  // power and reset control
  output logic pa_enable,
  output logic cfg_reset,
  output logic cfg_domain_on,
  output logic sysctl_domain_on,
  output logic bus_domain_on
);

  sms_sense_if sns ();                     // comparator lines to the synchroniser

  sms_pkg::sms_mode_t mode;                // decoded power mode
  sms_pkg::sms_seq_t state_r;              // restart sequencer state
  sms_pkg::sms_seq_t state_nxt;
  logic [sms_pkg::SMS_CNT_W-1:0] cnt_r;    // reset hold counter
  logic [sms_pkg::SMS_CNT_W-1:0] cnt_nxt;
  logic [7:0] flags_r;                     // stored condition flags
  logic [7:0] flags_nxt;
  logic [7:0] rd_data_r;                   // read answer
  logic [7:0] rd_data_nxt;
  logic rd_hit_r;
  logic rd_hit_nxt;
  logic cfg_reset_r;                       // registered power control
  logic cfg_on_r;
  logic sysctl_on_r;
  logic bus_on_r;
  logic cfg_reset_nxt;
  logic cfg_on_nxt;
  logic sysctl_on_nxt;
  logic bus_on_nxt;
  logic collapse_now;                      // monitored rail below collapse level
  logic collapse_evt;                      // collapse while monitoring
  logic rd_take;                           // read of the condition register
  logic lb_sense;                          // low battery detector enabled
  logic [7:0] set_vec;                     // flags raised this cycle

  // raw comparator lines into the synchroniser
  assign sns.raw = {lbd_below_early, lbd_below_deep, bod_vbat_low, bod_regulated_rail_low};

  sms_sync3 u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .sns (sns.sync)
  );

  // mode decode; the unused code counts as sleep
  always_comb begin
    unique case (mode_sel)
      sms_pkg::SMS_MODE_STANDBY: mode = sms_pkg::SMS_MODE_STANDBY;
      sms_pkg::SMS_MODE_ACTIVE: mode = sms_pkg::SMS_MODE_ACTIVE;
      default: mode = sms_pkg::SMS_MODE_SLEEP;
    endcase
  end

  // collapse detector, rail chosen by mode
  always_comb begin
    // quiet default keeps the unused mode code from holding a stale level
    collapse_now = 1'b0;
    unique case (mode)
      sms_pkg::SMS_MODE_ACTIVE:
        collapse_now = sns.clean[sms_pkg::SMS_SNS_REGULATED_RAIL];
      sms_pkg::SMS_MODE_STANDBY:
        collapse_now = sns.clean[sms_pkg::SMS_SNS_REGULATED_RAIL] | sns.clean[sms_pkg::SMS_SNS_VBAT];
      sms_pkg::SMS_MODE_SLEEP:
        collapse_now = 1'b0;  // only the bus is powered in sleep
    endcase
    collapse_evt = collapse_now & ((state_r == sms_pkg::SMS_ST_RUN) |
                                   (state_r == sms_pkg::SMS_ST_POR));
    lb_sense = (mode == sms_pkg::SMS_MODE_ACTIVE) & (state_r == sms_pkg::SMS_ST_RUN);
  end

  // amplifier may run only in a settled active state with a healthy rail
  assign pa_enable = pa_on_req & ~collapse_now & (state_r == sms_pkg::SMS_ST_RUN) &
                     (mode == sms_pkg::SMS_MODE_ACTIVE) & ~cfg_reset_r;

  // restart sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      sms_pkg::SMS_ST_POR: begin
        if (collapse_now) begin
          state_nxt = sms_pkg::SMS_ST_COLLAPSE;
        end else if (cnt_r == sms_pkg::SMS_POR_LAST) begin
          state_nxt = (mode == sms_pkg::SMS_MODE_SLEEP) ? sms_pkg::SMS_ST_SLEEP :
                                                          sms_pkg::SMS_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      sms_pkg::SMS_ST_RUN: begin
        if (collapse_now) begin
          state_nxt = sms_pkg::SMS_ST_COLLAPSE;
        end else if (mode == sms_pkg::SMS_MODE_SLEEP) begin
          state_nxt = sms_pkg::SMS_ST_SLEEP;
        end
      end
      sms_pkg::SMS_ST_COLLAPSE: begin
        // rail back: start over exactly as after power-up
        if (!collapse_now) begin
          state_nxt = sms_pkg::SMS_ST_POR;
          cnt_nxt = sms_pkg::SMS_CNT_ZERO;
        end
      end
      sms_pkg::SMS_ST_SLEEP: begin
        // leaving sleep: configuration is treated as reset
        if (mode != sms_pkg::SMS_MODE_SLEEP) begin
          state_nxt = sms_pkg::SMS_ST_POR;
          cnt_nxt = sms_pkg::SMS_CNT_ZERO;
        end
      end
    endcase
  end

  // power and reset control follows the next state
  always_comb begin
    cfg_reset_nxt = (state_nxt != sms_pkg::SMS_ST_RUN);
    cfg_on_nxt = (state_nxt != sms_pkg::SMS_ST_SLEEP);
    sysctl_on_nxt = (state_nxt != sms_pkg::SMS_ST_SLEEP);
    bus_on_nxt = 1'b1;
  end

  // condition flag next values; a set beats a clear in the same cycle
  always_comb begin
    rd_take = reg_rd_stb & (reg_rd_addr == sms_pkg::SMS_ADDR_COND);
    set_vec = sms_pkg::SMS_BYTE_ZERO;
    set_vec[sms_pkg::SMS_BIT_PARITY] = parity_mismatch;
    set_vec[sms_pkg::SMS_BIT_LOCK] = synth_unlock;
    set_vec[sms_pkg::SMS_BIT_LB_DEEP] = lb_sense & sns.clean[sms_pkg::SMS_SNS_LB_DEEP];
    set_vec[sms_pkg::SMS_BIT_LB_EARLY] = lb_sense & sns.clean[sms_pkg::SMS_SNS_LB_EARLY];
    flags_nxt = flags_r;
    if (rd_take) begin
      flags_nxt = flags_nxt & ~sms_pkg::SMS_COND_CLR_RD;
    end
    if (tx_start) begin
      flags_nxt = flags_nxt & ~sms_pkg::SMS_COND_LB;
    end
    flags_nxt = (flags_nxt | set_vec) & sms_pkg::SMS_COND_IMPL;
    if (collapse_evt) begin
      // back to the power-up picture, which shows the collapse bit set
      flags_nxt = sms_pkg::SMS_COND_RST;
    end
  end

  // read answer, one cycle after the strobe
  always_comb begin
    rd_data_nxt = rd_data_r;
    rd_hit_nxt = 1'b0;
    if (reg_rd_stb) begin
      rd_hit_nxt = rd_take;
      rd_data_nxt = rd_take ? ((flags_r & sms_pkg::SMS_COND_IMPL) | sms_pkg::SMS_COND_FIXED1)
                            : sms_pkg::SMS_BYTE_ZERO;
    end
  end

  // registers; power-up reset enters the same state as a collapse restart
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= sms_pkg::SMS_ST_POR;
      cnt_r <= sms_pkg::SMS_CNT_ZERO;
      flags_r <= sms_pkg::SMS_COND_RST;
      rd_data_r <= sms_pkg::SMS_BYTE_ZERO;
      rd_hit_r <= 1'b0;
      cfg_reset_r <= 1'b1;
      cfg_on_r <= 1'b1;
      sysctl_on_r <= 1'b1;
      bus_on_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      flags_r <= flags_nxt;
      rd_data_r <= rd_data_nxt;
      rd_hit_r <= rd_hit_nxt;
      cfg_reset_r <= cfg_reset_nxt;
      cfg_on_r <= cfg_on_nxt;
      sysctl_on_r <= sysctl_on_nxt;
      bus_on_r <= bus_on_nxt;
    end
  end

  // outputs
  assign reg_rd_data = rd_data_r;
  assign reg_rd_hit = rd_hit_r;
  assign cfg_reset = cfg_reset_r;
  assign cfg_domain_on = cfg_on_r;
  assign sysctl_domain_on = sysctl_on_r;
  assign bus_domain_on = bus_on_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  pa_off_collapse_a: assert property (collapse_now |-> !pa_enable)
    else $error("amplifier enabled during supply collapse");

  cfg_reset_collapse_a: assert property (
    (state_r == sms_pkg::SMS_ST_RUN && collapse_now) |=> cfg_reset_r [*2])
    else $error("configuration reset missing after collapse");

  restart_power_up_a: assert property (
    (state_r == sms_pkg::SMS_ST_COLLAPSE && !collapse_now)
    |=> (state_r == sms_pkg::SMS_ST_POR && cnt_r == sms_pkg::SMS_CNT_ZERO))
    else $error("collapse recovery did not restart from power-up state");

  collapse_read_a: assert property (
    (state_r == sms_pkg::SMS_ST_RUN && collapse_now) ##1 (reg_rd_stb && rd_take)
    |=> (rd_hit_r && rd_data_r[sms_pkg::SMS_BIT_COLLAPSE]))
    else $error("collapse not reported in condition register");

  standby_vbat_a: assert property (
    (state_r == sms_pkg::SMS_ST_RUN && mode == sms_pkg::SMS_MODE_STANDBY &&
     sns.clean[sms_pkg::SMS_SNS_VBAT]) |=> (state_r == sms_pkg::SMS_ST_COLLAPSE))
    else $error("battery rail not watched in standby");

  lb_idle_hold_a: assert property (
    (mode != sms_pkg::SMS_MODE_ACTIVE && !flags_r[sms_pkg::SMS_BIT_LB_DEEP] && !collapse_evt)
    |=> !flags_r[sms_pkg::SMS_BIT_LB_DEEP])
    else $error("deep low battery flag set outside active mode");

  lb_early_set_a: assert property (
    (lb_sense && sns.clean[sms_pkg::SMS_SNS_LB_EARLY] && !collapse_evt)
    |=> flags_r[sms_pkg::SMS_BIT_LB_EARLY] && !flags_r[sms_pkg::SMS_BIT_COLLAPSE + 1])
    else $error("early low battery flag not set");

  lb_tx_clear_a: assert property (
    (tx_start && !lb_sense && !collapse_evt)
    |=> !flags_r[sms_pkg::SMS_BIT_LB_DEEP] && !flags_r[sms_pkg::SMS_BIT_LB_EARLY])
    else $error("transmit start left a low battery flag set");

  parity_set_a: assert property (
    (parity_mismatch && !collapse_evt) |=> flags_r[sms_pkg::SMS_BIT_PARITY])
    else $error("parity mismatch not flagged");

  flag_sticky_a: assert property (
    (flags_r[sms_pkg::SMS_BIT_PARITY] && !rd_take && !collapse_evt)
    |=> flags_r[sms_pkg::SMS_BIT_PARITY])
    else $error("parity flag dropped without a read");

  standby_power_a: assert property (
    (state_r == sms_pkg::SMS_ST_RUN && mode == sms_pkg::SMS_MODE_STANDBY)
    |-> (cfg_on_r && sysctl_on_r && bus_on_r))
    else $error("standby removed power from retained logic");

  sleep_power_a: assert property (
    (state_r == sms_pkg::SMS_ST_SLEEP) |-> (!cfg_on_r && !sysctl_on_r && bus_on_r && cfg_reset_r))
    else $error("sleep power state wrong");

  // settled run with sleep selected must drop into sleep next edge
  sleep_entry_a: assert property (
    (state_r == sms_pkg::SMS_ST_RUN && mode == sms_pkg::SMS_MODE_SLEEP)
    |=> (state_r == sms_pkg::SMS_ST_SLEEP))
    else $error("run did not enter sleep");

  // any state but run keeps the configuration registers in reset
  cfg_hold_a: assert property (
    (state_r != sms_pkg::SMS_ST_RUN) |-> cfg_reset_r)
    else $error("configuration released outside run");

  // a collapse reloads the power-up picture of the flags
  collapse_reload_a: assert property (
    collapse_evt |=> (flags_r == sms_pkg::SMS_COND_RST))
    else $error("flags not reloaded after collapse");

  // lock fault raises its flag one edge later
  lock_set_a: assert property (
    (synth_unlock && !collapse_evt) |=> flags_r[sms_pkg::SMS_BIT_LOCK])
    else $error("lock fault not flagged");

  // a read with no new fault leaves all error flags clear
  read_clear_a: assert property (
    (rd_take && !parity_mismatch && !synth_unlock && !collapse_evt)
    |=> ((flags_r & sms_pkg::SMS_COND_CLR_RD) == sms_pkg::SMS_BYTE_ZERO))
    else $error("error flags survived a read");

endmodule : sms_supply_monitor

/* test/sms_host_model.sv */
/*
 * sms_host_model: host microcontroller side of the condition register read port.
 * assumes: the bench calls read_reg; one read at a time, on the device clock.
 */
`timescale 1ns/10ps
module sms_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // power mode the host has selected
  input wire logic [1:0] mode_sel,
  // register read port of the device
  output logic reg_rd_stb,
  output logic [sms_pkg::SMS_ADDR_W-1:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_hit,
  // low battery bits may be acted on
  output logic lb_usable
);
  // idle port, no strobe before the bench asks
  initial begin
    reg_rd_stb = 1'b0;
    reg_rd_addr = '0;
  end

  // low battery bits carry no meaning in standby
  assign lb_usable = rst_b && (mode_sel != sms_pkg::SMS_MODE_STANDBY);

  // one read: strobe for one edge, answer taken one edge later
  task automatic read_reg(input logic [sms_pkg::SMS_ADDR_W-1:0] addr, output logic [7:0] data,
                          output logic hit);
    @(posedge clock);
    reg_rd_stb <= 1'b1;
    reg_rd_addr <= addr;
    @(posedge clock);
    reg_rd_stb <= 1'b0;
    // released address shows the inverse so no stale value is trusted
    reg_rd_addr <= ~addr;
    #1;
    data = reg_rd_data;
    hit = reg_rd_hit;
  endtask : read_reg
endmodule : sms_host_model

/* test/sms_supply_monitor_tb.sv */
/*
 * sms_supply_monitor_tb: self-checking bench of the supply monitor block.
 * assumes: host model makes all reads; comparators and mode driven here.
 */
`timescale 1ns/10ps
module sms_supply_monitor_tb;
  // clock, reset and stimulus
  logic clock, rst_b, tx_start, pa_on_req, bod_regulated_rail_low, bod_vbat_low;
  logic lbd_below_deep, lbd_below_early, parity_mismatch, synth_unlock;
  logic [1:0] mode_sel;
  // observed outputs
  logic reg_rd_stb, reg_rd_hit, pa_enable, cfg_reset, lb_usable, rd_hit;
  logic cfg_domain_on, sysctl_domain_on, bus_domain_on;
  logic [sms_pkg::SMS_ADDR_W-1:0] reg_rd_addr;
  logic [7:0] reg_rd_data, rd_val;
  // bookkeeping
  int fail_count, num_checks, n;
  localparam int HOLD = sms_pkg::SMS_POR_HOLD_CYC;

  // device under test
  sms_supply_monitor DUT (.clock, .rst_b, .mode_sel, .tx_start, .pa_on_req, .bod_regulated_rail_low,
    .bod_vbat_low, .lbd_below_deep, .lbd_below_early, .parity_mismatch, .synth_unlock,
    .reg_rd_stb, .reg_rd_addr, .reg_rd_data, .reg_rd_hit, .pa_enable, .cfg_reset,
    .cfg_domain_on, .sysctl_domain_on, .bus_domain_on);

  // host on the read port
  sms_host_model host (.clock, .rst_b, .mode_sel, .reg_rd_stb, .reg_rd_addr, .reg_rd_data,
    .reg_rd_hit, .lb_usable);

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // counts, verdict, stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // compare one value and count it
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // read the condition register and compare hit and value
  task automatic rd_chk(input string what, input logic [7:0] exp);
    host.read_reg(sms_pkg::SMS_ADDR_COND, rd_val, rd_hit);
    chk({what, " hit"}, 8'h01, {7'h00, rd_hit});
    chk(what, exp, rd_val);
  endtask : rd_chk

  // bounded wait for cfg_reset to reach a level, cycles counted
  task automatic wait_cfg(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (cfg_reset !== lvl) begin
      @(posedge clock);
      #1;
      cnt++;
      if (cnt > lim) begin
        fail_count++;
        $display("CHECK FAILED cfg_reset wait expected %h seen %h", lvl, cfg_reset);
        end_of_test();
      end
    end
  endtask : wait_cfg

  // power-up hold, reset flags, clear on read, unmapped address
  task automatic test_por();
    wait_cfg(1'b0, 300, n);
    chk("power-up hold", 8'h01, (n == HOLD) ? 8'h01 : 8'h00);
    rd_chk("reset flags", 8'h84);
    rd_chk("flags after read", 8'h80);
    host.read_reg(6'h02, rd_val, rd_hit);
    chk("unmapped data", 8'h00, rd_val);
    chk("unmapped hit", 8'h00, {7'h00, rd_hit});
    $display("test_por done");
  endtask : test_por

  // parity and lock faults held until read
  task automatic test_faults();
    @(posedge clock);
    parity_mismatch <= 1'b1;
    synth_unlock <= 1'b1;
    @(posedge clock);
    parity_mismatch <= 1'b0;
    synth_unlock <= 1'b0;
    repeat (20) @(posedge clock);
    rd_chk("fault flags", 8'h83);
    rd_chk("fault flags read", 8'h80);
    $display("test_faults done");
  endtask : test_faults

  // low battery sensing, both thresholds, cleared by transmit start
  task automatic test_lowbatt();
    @(posedge clock);
    lbd_below_deep <= 1'b1;
    lbd_below_early <= 1'b1;
    repeat (10) @(posedge clock);
    lbd_below_deep <= 1'b0;
    lbd_below_early <= 1'b0;
    repeat (8) @(posedge clock);
    rd_chk("battery in standby", 8'h80);
    chk("host ignores standby", 8'h00, {7'h00, lb_usable});
    @(posedge clock);
    mode_sel <= sms_pkg::SMS_MODE_ACTIVE;
    lbd_below_deep <= 1'b1;
    repeat (10) @(posedge clock);
    lbd_below_deep <= 1'b0;
    repeat (8) @(posedge clock);
    rd_chk("deep flag", 8'hA0);
    chk("host uses active", 8'h01, {7'h00, lb_usable});
    @(posedge clock);
    lbd_below_early <= 1'b1;
    repeat (10) @(posedge clock);
    lbd_below_early <= 1'b0;
    repeat (8) @(posedge clock);
    rd_chk("both flags", 8'hB0);
    @(posedge clock);
    tx_start <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    rd_chk("flags after start", 8'h80);
    $display("test_lowbatt done");
  endtask : test_lowbatt

  // collapse in active: battery dip ignored, regulated rail acts
  task automatic test_collapse();
    @(posedge clock);
    pa_on_req <= 1'b1;
    bod_vbat_low <= 1'b1;
    repeat (10) @(posedge clock);
    #1;
    chk("amplifier on battery dip", 8'h01, {7'h00, pa_enable});
    @(posedge clock);
    bod_vbat_low <= 1'b0;
    parity_mismatch <= 1'b1;
    @(posedge clock);
    parity_mismatch <= 1'b0;
    bod_regulated_rail_low <= 1'b1;
    wait_cfg(1'b1, 8, n);
    chk("amplifier in collapse", 8'h00, {7'h00, pa_enable});
    @(posedge clock);
    bod_regulated_rail_low <= 1'b0;
    wait_cfg(1'b0, 300, n);
    chk("restart hold", 8'h01, (n >= HOLD) ? 8'h01 : 8'h00);
    chk("amplifier after restart", 8'h01, {7'h00, pa_enable});
    rd_chk("flags after collapse", 8'h84);
    @(posedge clock);
    pa_on_req <= 1'b0;
    $display("test_collapse done");
  endtask : test_collapse

  // collapse in standby follows the battery rail too
  task automatic test_standby_collapse();
    @(posedge clock);
    mode_sel <= sms_pkg::SMS_MODE_STANDBY;
    bod_vbat_low <= 1'b1;
    wait_cfg(1'b1, 8, n);
    @(posedge clock);
    bod_vbat_low <= 1'b0;
    wait_cfg(1'b0, 300, n);
    rd_chk("standby collapse flag", 8'h84);
    $display("test_standby_collapse done");
  endtask : test_standby_collapse

  // supply domains in standby and sleep, restart after sleep
  task automatic test_power();
    #1;
    chk("standby registers", 8'h07, {5'h00, cfg_domain_on, sysctl_domain_on, bus_domain_on});
    @(posedge clock);
    mode_sel <= sms_pkg::SMS_MODE_SLEEP;
    repeat (3) @(posedge clock);
    #1;
    chk("sleep domains", 8'h03, {5'h00, cfg_domain_on, sysctl_domain_on, bus_domain_on,
      cfg_reset});
    @(posedge clock);
    mode_sel <= 2'h3;
    repeat (3) @(posedge clock);
    #1;
    chk("unused code as sleep", 8'h03, {5'h00, cfg_domain_on, sysctl_domain_on, bus_domain_on,
      cfg_reset});
    @(posedge clock);
    mode_sel <= sms_pkg::SMS_MODE_STANDBY;
    wait_cfg(1'b0, 300, n);
    chk("hold after sleep", 8'h01, (n >= HOLD) ? 8'h01 : 8'h00);
    chk("registers back", 8'h01, {7'h00, cfg_domain_on});
    $display("test_power done");
  endtask : test_power

  // main sequence
  initial begin
    rst_b = 1'b0;
    mode_sel = sms_pkg::SMS_MODE_STANDBY;
    {tx_start, pa_on_req, bod_regulated_rail_low, bod_vbat_low} = 4'h0;
    {lbd_below_deep, lbd_below_early, parity_mismatch, synth_unlock} = 4'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    test_por();
    test_faults();
    test_lowbatt();
    test_collapse();
    test_standby_collapse();
    test_power();
    end_of_test();
  end
endmodule : sms_supply_monitor_tb
